// ==== dvfm_device.sv ====
// Mode-register bank of the DRAM: set points, reference level, invert mask
// Function
// RULE_01: Training bit set enters command bus training
// RULE_02: Training, clock enable low: mirror CA onto DQ
// RULE_03: Controller raises clock enable before leaving training
// RULE_04: Reference output drives active set point levels
// RULE_05: Fast-current bit selects high-current reference mode
// RULE_06: Rate option valid only when info bit set
// RULE_07: Option clear reports code three for one/two
// RULE_08: Controller follows reported refresh-rate field
// RULE_09: Self-refresh compensation ignores rate option
// RULE_10: Mask disable forbids masked writes
// RULE_11: Write select picks set point that writes update
// RULE_12: Device operates only on operating set point
// RULE_13: Reference codes above 110010B are reserved
// RULE_14: Bit six selects reference range with level
// RULE_15: Reference setting persists until written or reset
// RULE_16: Reads return eight bits, reserved as zero
// RULE_17: Write select picks copy for writes, reads
// RULE_18: Invert register flips calibration lanes per bit
// RULE_19: Set-point control register at address 0DH
// RULE_20: Calibration never inverts mask lane zero
// RULE_21: Calibration applies no data bus inversion
// RULE_22: Controller waits for reference settling after change
`timescale 1ns/100ps
module dvfm_device
  import dvfm_pkg::*;
(
  input wire logic core_clk, // System clock, 50 MHz
  input wire logic reset, // Asynchronous reset, active high
  dvfm_link_if.device link, // Link to the controller
  input wire logic info_rate_opt_ok, // Device-info bit zero
  input wire logic dbi_enable, // Data bus inversion enable, io config
  input wire logic [2:0] temp_rate_code, // Raw temperature rate code
  input wire logic [7:0] cal_pattern, // Calibration pattern, lanes 7..0
  input wire logic cal_pattern_dmi, // Calibration pattern, mask lane
  output logic training_active, // Command bus training mode
  output logic preamble_training, // Read preamble training enable
  output logic ref_output_en, // Reference output mode
  output logic fast_current_en, // High-current reference mode
  output logic mask_enable, // Data masking supported
  output logic [6:0] dq_vref_active, // Range and level in use
  output logic [2:0] refresh_rate_status, // Reported refresh rate
  output logic [2:0] self_refresh_rate, // Compensated self-refresh rate
  output logic masked_write_illegal // Sticky: masked write while disabled
);

  // Command parser phases
  typedef enum logic [1:0] {
    PH_CMD,
    PH_ADDR,
    PH_OP_LO,
    PH_OP_HI
  } dvfm_phase_t;

  // All device state
  typedef struct packed {
    logic [1:0] ck_s; // Link clock synchroniser
    logic [1:0] cke_s; // Clock enable synchroniser
    logic [1:0] rstn_s; // Link reset synchroniser
    logic [5:0] ca_s1; // CA first stage
    logic [5:0] ca_s2; // CA second stage
    logic ck_prev; // Previous synchronised link clock
    dvfm_phase_t phase; // Parser phase
    logic [5:0] cmd; // Command of the frame
    logic [5:0] addr; // Mode address of the frame
    logic [5:0] op_lo; // Low operand bits
    logic [7:0] spc; // set_point_control_reg
    logic [7:0] ref0; // dq_reference_level, set point 0
    logic [7:0] ref1; // dq_reference_level, set point 1
    logic [7:0] inv; // dq_calibration_invert_low
    logic [1:0] resp_left; // Link edges left on a response
    logic [7:0] resp_data; // Response data lanes
    logic resp_dmi; // Response mask lane
    logic [7:0] dq_out; // Data drive
    logic dq_oe; // Data enable
    logic dmi_out; // Mask lane drive
    logic dmi_oe; // Mask lane enable
    logic illegal; // Masked write seen while disabled
    logic [6:0] vref_act; // Active range and level
    logic [2:0] rate; // Reported refresh rate
    logic [2:0] sr_rate; // Self-refresh rate
  } dvfm_dev_st_t;

  dvfm_dev_st_t st_reg;
  dvfm_dev_st_t st_next;
  logic rise; // Link clock rising edge seen
  logic [7:0] op_full; // Operand of a mode write
  logic [7:0] wr_copy; // Copy chosen by the write select
  logic train_mirror; // Training with clock enable low

  // Pick one of two set-point copies
  function automatic logic [7:0] pick_copy(input logic sel,
    input logic [7:0] c0, input logic [7:0] c1);
    pick_copy = sel ? c1 : c0;
  endfunction

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.ck_s = {st_reg.ck_s[0], link.ck};
    st_next.cke_s = {st_reg.cke_s[0], link.cke};
    st_next.rstn_s = {st_reg.rstn_s[0], link.reset_n};
    st_next.ca_s1 = link.ca;
    st_next.ca_s2 = st_reg.ca_s1;
    st_next.ck_prev = st_reg.ck_s[1];
    rise = st_reg.ck_s[1] & ~st_reg.ck_prev;
    op_full = {st_reg.ca_s2[1:0], st_reg.op_lo};
    wr_copy = pick_copy(st_reg.spc[SPC_WR_SEL], st_reg.ref0,
      st_reg.ref1); // RULE_17
    train_mirror = st_reg.spc[SPC_TRAIN] & ~st_reg.cke_s[1];
    // Count down a standing response on each link rising edge
    if (rise && st_reg.resp_left != 2'h0) begin
      st_next.resp_left = st_reg.resp_left - 2'h1;
    end
    if (train_mirror) begin
      // Commands ignored while training with clock enable low
      st_next.phase = PH_CMD; // RULE_02
    end else if (rise) begin
      unique case (st_reg.phase)
        PH_CMD: begin
          st_next.cmd = st_reg.ca_s2;
          if (st_reg.ca_s2 == CMD_MODE_WR ||
              st_reg.ca_s2 == CMD_MODE_RD) begin
            st_next.phase = PH_ADDR;
          end else if (st_reg.ca_s2 == CMD_MASK_WR) begin
            // Masked write is illegal once masking is disabled
            if (st_reg.spc[SPC_MASK_DIS]) begin
              st_next.illegal = 1'b1; // RULE_10
            end
          end else if (st_reg.ca_s2 == CMD_CAL_RD) begin
            // Invert per lane; mask lane and inversion untouched
            st_next.resp_data = cal_pattern ^ st_reg.inv; // RULE_18 RULE_21
            st_next.resp_dmi = cal_pattern_dmi; // RULE_20
            st_next.resp_left = RESP_EDGES_CAL;
          end
        end
        PH_ADDR: begin
          st_next.addr = st_reg.ca_s2;
          if (st_reg.cmd == CMD_MODE_RD) begin
            st_next.phase = PH_CMD;
            st_next.resp_left = RESP_EDGES_RD;
            st_next.resp_dmi = 1'b0;
            // Read data on lanes 7..0, reserved bits zero
            if (st_reg.ca_s2 == MA_DQ_REF_LEVEL) begin
              st_next.resp_data = wr_copy; // RULE_16 RULE_17
            end else if (st_reg.ca_s2 == MA_REFRESH_STATUS) begin
              st_next.resp_data = {5'h00, st_reg.rate};
            end else begin
              st_next.resp_data = 8'h00; // RULE_16
            end
          end else begin
            st_next.phase = PH_OP_LO;
          end
        end
        PH_OP_LO: begin
          st_next.op_lo = st_reg.ca_s2;
          st_next.phase = PH_OP_HI;
        end
        PH_OP_HI: begin
          st_next.phase = PH_CMD;
          if (st_reg.addr == MA_SET_POINT_CTRL) begin
            // Control bits, training entry/exit by bit zero
            st_next.spc = op_full; // RULE_19 RULE_01
          end else if (st_reg.addr == MA_DQ_REF_LEVEL) begin
            // Range and level written together into one copy
            if (st_reg.spc[SPC_WR_SEL]) begin
              st_next.ref1 = {1'b0, op_full[DQREF_RANGE],
                op_full[5:0]}; // RULE_11 RULE_14 RULE_17
            end else begin
              st_next.ref0 = {1'b0, op_full[DQREF_RANGE],
                op_full[5:0]}; // RULE_11 RULE_14 RULE_17
            end
          end else if (st_reg.addr == MA_DQ_CAL_INVERT) begin
            st_next.inv = op_full; // RULE_18
          end
        end
      endcase
    end
    // Operating copy alone drives the reference
    st_next.vref_act = 7'(pick_copy(st_reg.spc[SPC_OP_SEL], st_reg.ref0,
      st_reg.ref1)); // RULE_12
    // Rate option only counts when the device-info bit allows it
    if (info_rate_opt_ok && !st_reg.spc[SPC_RATE_OPT] &&
        (temp_rate_code == RATE_CODE_A ||
         temp_rate_code == RATE_CODE_B)) begin
      st_next.rate = RATE_CODE_SUB; // RULE_06 RULE_07
    end else begin
      st_next.rate = temp_rate_code; // RULE_06
    end
    // Self-refresh follows the raw code whatever the option
    st_next.sr_rate = temp_rate_code; // RULE_09
    // Data lanes: mirror, then response, then reference output
    if (train_mirror) begin
      st_next.dq_out = {2'b00, st_reg.ca_s2}; // RULE_02
      st_next.dq_oe = 1'b1;
      st_next.dmi_oe = 1'b0;
    end else if (st_next.resp_left != 2'h0) begin
      st_next.dq_out = st_next.resp_data;
      st_next.dq_oe = 1'b1;
      st_next.dmi_out = st_next.resp_dmi;
      st_next.dmi_oe = 1'b1;
    end else if (st_reg.spc[SPC_REF_OUT]) begin
      // Active set point level only, range in bit six
      st_next.dq_out = {1'b0, st_next.vref_act}; // RULE_04
      st_next.dq_oe = 1'b1;
      st_next.dmi_oe = 1'b0;
    end else begin
      st_next.dq_oe = 1'b0;
      st_next.dmi_oe = 1'b0;
    end
    // Link reset returns registers to their reset values
    if (!st_reg.rstn_s[1]) begin
      st_next.spc = SPC_RST;
      st_next.ref0 = DQREF_RST; // RULE_15
      st_next.ref1 = DQREF_RST; // RULE_15
      st_next.inv = INV_RST;
      st_next.phase = PH_CMD;
      st_next.resp_left = 2'h0;
      st_next.illegal = 1'b0;
      st_next.dq_oe = 1'b0;
      st_next.dmi_oe = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '{ck_s: 2'b00, cke_s: 2'b00, rstn_s: 2'b00,
        ca_s1: 6'h00, ca_s2: 6'h00, ck_prev: 1'b0, phase: PH_CMD,
        cmd: 6'h00, addr: 6'h00, op_lo: 6'h00, spc: SPC_RST,
        ref0: DQREF_RST, ref1: DQREF_RST, inv: INV_RST,
        resp_left: 2'h0, resp_data: 8'h00, resp_dmi: 1'b0,
        dq_out: 8'h00, dq_oe: 1'b0, dmi_out: 1'b0, dmi_oe: 1'b0,
        illegal: 1'b0, vref_act: DQREF_RST[6:0], rate: 3'h0,
        sr_rate: 3'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state
  assign link.dq_out = st_reg.dq_out;
  assign link.dq_oe = st_reg.dq_oe;
  assign link.dmi_out = st_reg.dmi_out;
  assign link.dmi_oe = st_reg.dmi_oe;
  assign training_active = st_reg.spc[SPC_TRAIN]; // RULE_01
  assign preamble_training = st_reg.spc[SPC_PREAMBLE];
  assign ref_output_en = st_reg.spc[SPC_REF_OUT]; // RULE_04
  assign fast_current_en = st_reg.spc[SPC_FAST_CUR]; // RULE_05
  assign mask_enable = ~st_reg.spc[SPC_MASK_DIS]; // RULE_10
  assign dq_vref_active = st_reg.vref_act;
  assign refresh_rate_status = st_reg.rate;
  assign self_refresh_rate = st_reg.sr_rate;
  assign masked_write_illegal = st_reg.illegal;

endmodule

// ==== dvfm_pkg.sv ====
// Shared constants for the mode-register device and its controller
package dvfm_pkg;
  // Mode addresses on the command/address link
  localparam logic [5:0] MA_REFRESH_STATUS = 6'h04;
  localparam logic [5:0] MA_SET_POINT_CTRL = 6'h0D;
  localparam logic [5:0] MA_DQ_REF_LEVEL = 6'h0E;
  localparam logic [5:0] MA_DQ_CAL_INVERT = 6'h0F;
  // Bit positions in set_point_control_reg
  localparam int SPC_TRAIN = 0;
  localparam int SPC_PREAMBLE = 1;
  localparam int SPC_REF_OUT = 2;
  localparam int SPC_FAST_CUR = 3;
  localparam int SPC_RATE_OPT = 4;
  localparam int SPC_MASK_DIS = 5;
  localparam int SPC_WR_SEL = 6;
  localparam int SPC_OP_SEL = 7;
  // Field of dq_reference_level
  localparam int DQREF_RANGE = 6;
  localparam logic [5:0] DQREF_MAX = 6'h32;
  // Values after reset
  localparam logic [7:0] SPC_RST = 8'h00;
  localparam logic [7:0] DQREF_RST = 8'h5D;
  localparam logic [7:0] INV_RST = 8'h00;
  // Refresh-rate codes
  localparam logic [2:0] RATE_CODE_A = 3'h1;
  localparam logic [2:0] RATE_CODE_B = 3'h2;
  localparam logic [2:0] RATE_CODE_SUB = 3'h3;
  // Command codes on the first beat of a frame
  localparam logic [5:0] CMD_NOP = 6'h00;
  localparam logic [5:0] CMD_MODE_WR = 6'h06;
  localparam logic [5:0] CMD_MASK_WR = 6'h0C;
  localparam logic [5:0] CMD_MODE_RD = 6'h0E;
  localparam logic [5:0] CMD_CAL_RD = 6'h18;
  // Beats in each frame and response lifetime in link rising edges
  localparam int FRAME_BEATS = 4;
  localparam logic [1:0] RESP_EDGES_RD = 2'h2;
  localparam logic [1:0] RESP_EDGES_CAL = 2'h3;
  // Controller register offsets on APB
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_LINK = 8'h08;
  // Command kinds in the command register
  localparam logic [1:0] KIND_MODE_WR = 2'h0;
  localparam logic [1:0] KIND_MODE_RD = 2'h1;
  localparam logic [1:0] KIND_MASK_WR = 2'h2;
  localparam logic [1:0] KIND_CAL_RD = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 160;
  localparam int CK_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int VREF_STEP_SETTLE_NS = 80;
  localparam int SETTLE_CYC_PER_STEP =
    (VREF_STEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== dvfm_link_if.sv ====
// Command/address link between controller and mode-register device
`timescale 1ns/100ps
interface dvfm_link_if;
  logic ck; // Link clock from controller
  logic cke; // Clock enable
  logic reset_n; // Link reset, active low
  logic [5:0] ca; // Command/address beats
  logic [7:0] dq_out; // Device data drive value
  logic dq_oe; // Device drives data
  logic dmi_out; // Device lane-0 mask/inversion drive
  logic dmi_oe; // Device drives mask/inversion lane
  wire [7:0] dq; // Resolved data lanes, terminated low
  wire dmi; // Resolved mask/inversion lane
  assign dq = dq_oe ? dq_out : 8'h00;
  assign dmi = dmi_oe ? dmi_out : 1'b0;
  modport device (input ck, input cke, input reset_n, input ca,
    output dq_out, output dq_oe, output dmi_out, output dmi_oe);
  modport controller (output ck, output cke, output reset_n, output ca,
    input dq, input dmi);
endinterface

// ==== dvfm_ctrl.sv ====
// Controller end: APB registers, link clock divider, command frames
`timescale 1ns/100ps
module dvfm_ctrl
  import dvfm_pkg::*;
(
  input wire logic core_clk, // System clock, 50 MHz
  input wire logic reset, // Asynchronous reset, active high
  dvfm_link_if.controller link, // Link to the device
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error on unmapped address
);

  // Controller phases
  typedef enum logic [1:0] {
    C_IDLE,
    C_SEND,
    C_SETTLE
  } dvfm_cstate_t;

  // All controller state
  typedef struct packed {
    logic [2:0] cnt; // Divider phase
    logic ck; // Link clock
    logic cke_sw; // Software clock enable
    logic rst_sw; // Software link reset
    logic [5:0] ca; // Current beat
    dvfm_cstate_t state; // Phase
    logic armed; // First beat issued
    logic [1:0] beat; // Beat index
    logic [FRAME_BEATS-1:0][5:0] beats; // Frame beats
    logic [17:0] cmd; // Last command word
    logic [7:0] rdata; // Read result
    logic refused; // Sticky refusal
    logic [8:0] settle; // Settle countdown
    logic [5:0] last_level; // Last reference code sent
    logic [7:0] spc_shadow; // Last control value sent
    logic [7:0] dq_s1; // Data first stage
    logic [7:0] dq_s2; // Data second stage
    logic [31:0] prdata; // Bus read data
    logic pready; // Bus ready
    logic pslverr; // Bus error
  } dvfm_ctrl_st_t;

  dvfm_ctrl_st_t st_reg;
  dvfm_ctrl_st_t st_next;
  logic access; // APB access phase
  logic [1:0] kind; // Requested kind
  logic [5:0] maddr; // Requested address
  logic [7:0] op; // Requested operand
  logic [5:0] diff; // Reference step size

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    access = psel & penable & ~st_reg.pready;
    kind = pwdata[17:16];
    maddr = pwdata[13:8];
    op = pwdata[7:0];
    diff = (op[5:0] > st_reg.last_level) ? op[5:0] - st_reg.last_level
      : st_reg.last_level - op[5:0];
    st_next.dq_s1 = link.dq;
    st_next.dq_s2 = st_reg.dq_s1;
    // Link clock divider, low in the first half
    st_next.cnt = st_reg.cnt + 3'h1;
    st_next.ck = (st_next.cnt >= 3'(CK_DIV / 2));
    // APB slave, one wait state
    st_next.pready = access;
    st_next.pslverr = 1'b0;
    st_next.prdata = 32'h0000_0000;
    if (access) begin
      unique case (paddr)
        APB_CMD: begin
          st_next.prdata = {14'h0000, st_reg.cmd};
          if (pwrite) begin
            if (st_reg.state != C_IDLE ||
                (kind == KIND_MASK_WR && st_reg.spc_shadow[SPC_MASK_DIS])
                || (kind == KIND_MODE_WR && maddr == MA_DQ_REF_LEVEL &&
                op[5:0] > DQREF_MAX)) begin
              st_next.refused = 1'b1; // RULE_10 RULE_13
            end else begin
              st_next.refused = 1'b0;
              st_next.cmd = pwdata[17:0];
              st_next.state = C_SEND;
              st_next.armed = 1'b0;
              st_next.beat = 2'h0;
              st_next.beats = {CMD_NOP, CMD_NOP, CMD_NOP, CMD_NOP};
              unique case (kind)
                KIND_MODE_WR: st_next.beats = {{4'h0, op[7:6]}, op[5:0],
                  maddr, CMD_MODE_WR};
                KIND_MODE_RD: st_next.beats = {CMD_NOP, CMD_NOP, maddr,
                  CMD_MODE_RD};
                KIND_MASK_WR: st_next.beats[0] = CMD_MASK_WR;
                KIND_CAL_RD: st_next.beats[0] = CMD_CAL_RD;
              endcase
              if (kind == KIND_MODE_WR && maddr == MA_SET_POINT_CTRL) begin
                st_next.spc_shadow = op;
                if (!op[SPC_TRAIN]) begin
                  st_next.cke_sw = 1'b1; // RULE_03
                end
              end
              if (kind == KIND_MODE_WR && maddr == MA_DQ_REF_LEVEL) begin
                st_next.last_level = op[5:0];
                st_next.settle = 9'(diff * SETTLE_CYC_PER_STEP); // RULE_22
              end
            end
          end
        end
        APB_STATUS: begin
          st_next.prdata = {16'h0000, st_reg.rdata, 6'h00,
            st_reg.refused, st_reg.state != C_IDLE}; // RULE_08
        end
        APB_LINK: begin
          st_next.prdata = {30'h0, st_reg.rst_sw, st_reg.cke_sw};
          if (pwrite) begin
            st_next.cke_sw = pwdata[0];
            st_next.rst_sw = pwdata[1];
          end
        end
        default: st_next.pslverr = 1'b1;
      endcase
    end
    // Frame sequencing, beats change while the link clock is low
    unique case (st_reg.state)
      C_IDLE: begin
      end
      C_SEND: begin
        if (st_reg.armed && st_reg.beat == 2'h3 && st_reg.cnt == 3'h3) begin
          st_next.rdata = st_reg.dq_s2;
        end
        if (st_reg.cnt == 3'(CK_DIV - 1)) begin
          if (!st_reg.armed) begin
            st_next.armed = 1'b1;
            st_next.ca = st_reg.beats[0];
          end else if (st_reg.beat == 2'h3) begin
            st_next.ca = CMD_NOP;
            st_next.state = (st_reg.settle != 9'h000) ? C_SETTLE : C_IDLE;
          end else begin
            st_next.beat = st_reg.beat + 2'h1;
            st_next.ca = st_reg.beats[st_reg.beat + 2'h1];
          end
        end
      end
      C_SETTLE: begin
        // Hold busy while the new reference level settles
        st_next.settle = st_reg.settle - 9'h001; // RULE_22
        if (st_reg.settle == 9'h001) begin
          st_next.state = C_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '{cnt: 3'h0, ck: 1'b0, cke_sw: 1'b1, rst_sw: 1'b0,
        ca: CMD_NOP, state: C_IDLE, armed: 1'b0, beat: 2'h0,
        beats: '0, cmd: 18'h00000, rdata: 8'h00, refused: 1'b0,
        settle: 9'h000, last_level: DQREF_RST[5:0], spc_shadow: SPC_RST,
        dq_s1: 8'h00, dq_s2: 8'h00, prdata: 32'h0000_0000,
        pready: 1'b0, pslverr: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state
  assign link.ck = st_reg.ck;
  assign link.cke = st_reg.cke_sw;
  assign link.reset_n = ~st_reg.rst_sw;
  assign link.ca = st_reg.ca;
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;

endmodule

// ==== dvfm_props.sv ====
// Link-side assertions for the mode-register link
`timescale 1ns/100ps
module dvfm_props
  import dvfm_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic reset, // Asynchronous reset
  input wire logic ck, // Link clock
  input wire logic cke, // Clock enable
  input wire logic reset_n, // Link reset, active low
  input wire logic [5:0] ca, // Command beats
  input wire logic dq_oe, // Device drives data
  input wire logic dmi_oe // Device drives mask lane
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Link clock halves last four core cycles
  chk_ck_high_len:
    assert property ($rose(ck) |-> ck [*4] ##1 !ck) else $error("ck high");
  chk_ck_low_len:
    assert property ($fell(ck) |-> !ck [*4] ##1 ck) else $error("ck low");
  // Beats change only while the link clock is low
  chk_ca_hold_high:
    assert property (ck && $past(ck) |-> $stable(ca)) else $error("ca moved");
  chk_ca_beat_hold:
    assert property ($changed(ca) |=> $stable(ca) [*7]) else $error("beat");
  chk_cke_clear_train:
    assert property (($past(ca) == CMD_MODE_WR && ca == MA_SET_POINT_CTRL)
      ##8 !ca[0] |-> cke) else $error("cke low at training exit");
  chk_read_drive_len:
    assert property ($rose(dq_oe) |-> dq_oe [*8]) else $error("dq drive");
  chk_mask_lane_cal:
    assert property (dmi_oe |-> dq_oe) else $error("mask lane alone");
  chk_quiet_link_rst:
    assert property (!reset_n [*4] |-> !dq_oe && !dmi_oe)
      else $error("drive in link reset");
endmodule

// ==== tb_dram_vref_fsp_mode_regs.sv ====
// Bench joining controller and device over the link
`timescale 1ns/100ps
module tb_dram_vref_fsp_mode_regs;
  import dvfm_pkg::*;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, perr;
  logic info_rate_opt_ok, dbi_enable, cal_pattern_dmi, preamble_training;
  logic training_active, ref_output_en, fast_current_en, mask_enable;
  logic masked_write_illegal;
  logic [2:0] temp_rate_code, refresh_rate_status, self_refresh_rate;
  logic [7:0] paddr, cal_pattern;
  logic [31:0] pwdata, prdata, rdata;
  logic [6:0] dq_vref_active;
  int fails, num_checks;
  dvfm_link_if link(); // Link joining both ends
  dvfm_device u_dvfm_device(.core_clk(core_clk), .reset(reset), .link(link),
    .info_rate_opt_ok(info_rate_opt_ok), .dbi_enable(dbi_enable),
    .temp_rate_code(temp_rate_code), .cal_pattern(cal_pattern),
    .cal_pattern_dmi(cal_pattern_dmi), .training_active(training_active),
    .preamble_training(preamble_training), .ref_output_en(ref_output_en),
    .fast_current_en(fast_current_en), .mask_enable(mask_enable),
    .dq_vref_active(dq_vref_active),
    .refresh_rate_status(refresh_rate_status),
    .self_refresh_rate(self_refresh_rate),
    .masked_write_illegal(masked_write_illegal));
  dvfm_ctrl u_dvfm_ctrl(.core_clk(core_clk), .reset(reset), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dvfm_props u_dvfm_props(.core_clk(core_clk), .reset(reset), .ck(link.ck),
    .cke(link.cke), .reset_n(link.reset_n), .ca(link.ca),
    .dq_oe(link.dq_oe), .dmi_oe(link.dmi_oe));
  // Core clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll status until the link goes idle
  task automatic wait_idle;
    int i;
    i = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      i++;
    end while (rdata[0] !== 1'b0 && i < 500);
    chk(rdata[0], 1'b0);
  endtask
  task automatic cmd(input logic [1:0] k, input logic [5:0] m,
    input logic [7:0] o);
    apb(1'b1, APB_CMD, {14'h0, k, 2'h0, m, o});
    wait_idle();
  endtask
  task automatic spc(input logic [7:0] v);
    cmd(KIND_MODE_WR, MA_SET_POINT_CTRL, v);
  endtask
  task automatic rd_ref(input logic [7:0] exp);
    cmd(KIND_MODE_RD, MA_DQ_REF_LEVEL, 8'h00);
    chk(rdata[15:8], exp);
  endtask
  // Set-point copies: write select and operating select
  task automatic t_regs;
    rd_ref(DQREF_RST);
    spc(8'h40);
    cmd(KIND_MODE_WR, MA_DQ_REF_LEVEL, 8'h32);
    rd_ref(8'h32);
    chk(dq_vref_active, 7'h5D);
    spc(8'h80);
    rd_ref(8'h5D);
    chk(dq_vref_active, 7'h32);
    cmd(KIND_MODE_WR, MA_DQ_REF_LEVEL, 8'h45);
    rd_ref(8'h45);
    chk(dq_vref_active, 7'h32);
  endtask
  // Reserved level code is refused, stored value kept
  task automatic t_refuse;
    cmd(KIND_MODE_WR, MA_DQ_REF_LEVEL, 8'h33);
    chk(rdata[1], 1'b1);
    rd_ref(8'h45);
  endtask
  // Refresh-rate substitution over all codes, three of the four info/option settings
  task automatic t_rate;
    for (int j = 0; j < 3; j++) begin
      if (j == 2) spc(8'h90);
      for (int c = 0; c < 8; c++) begin
        info_rate_opt_ok <= (j != 1);
        temp_rate_code <= c[2:0];
        repeat (3) @(posedge core_clk);
        chk(refresh_rate_status, (j == 0 && (c == 1 || c == 2)) ?
          RATE_CODE_SUB : c[2:0]);
        chk(self_refresh_rate, c[2:0]);
      end
    end
    spc(8'h80);
  endtask
  // Masked writes refused while masking is disabled
  task automatic t_mask;
    chk(mask_enable, 1'b1);
    spc(8'hA0);
    chk(mask_enable, 1'b0);
    cmd(KIND_MASK_WR, 6'h00, 8'h00);
    chk(rdata[1], 1'b1);
    spc(8'h80);
    cmd(KIND_MASK_WR, 6'h00, 8'h00);
    chk({rdata[1], masked_write_illegal}, 2'b00);
  endtask
  // Calibration read with per-lane invert, inversion enabled
  task automatic t_cal;
    cmd(KIND_MODE_WR, MA_DQ_CAL_INVERT, 8'h15);
    dbi_enable <= 1'b1;
    cal_pattern <= 8'hA5;
    cal_pattern_dmi <= 1'b1;
    cmd(KIND_CAL_RD, 6'h00, 8'h00);
    chk(rdata[15:8], 8'hB0);
    cal_pattern_dmi <= 1'b0;
  endtask
  // Mask lane always carries the true pattern
  always @(posedge core_clk) if (link.dmi_oe === 1'b1)
    chk(link.dmi, cal_pattern_dmi);
  // Training mirrors beats onto the data lanes
  task automatic t_train;
    int i;
    spc(8'h81);
    chk(training_active, 1'b1);
    apb(1'b1, APB_LINK, 32'h0);
    apb(1'b1, APB_CMD, {14'h0, KIND_MODE_RD, 2'h0, MA_DQ_REF_LEVEL, 8'h00});
    for (i = 0; i < 100 && link.ca !== CMD_MODE_RD; i++) @(posedge core_clk);
    repeat (6) @(posedge core_clk);
    chk(link.dq, {2'b00, CMD_MODE_RD});
    wait_idle();
    spc(8'h80);
    chk({training_active, link.cke}, 2'b01);
  endtask
  // Control bits and reference output of the operating copy
  task automatic t_refout;
    spc(8'h8E);
    chk({ref_output_en, fast_current_en, preamble_training}, 3'h7);
    chk(link.dq, 8'h32);
    spc(8'h80);
  endtask
  // Link reset reloads both copies, set point 0 seen active and set point 1 read back; unmapped APB offset
  task automatic t_linkrst;
    apb(1'b1, APB_LINK, 32'h3);
    repeat (6) @(posedge core_clk);
    apb(1'b1, APB_LINK, 32'h1);
    chk(dq_vref_active, 7'h5D);
    spc(8'hC0);
    rd_ref(8'h5D);
    apb(1'b0, 8'h0C, 32'h0);
    chk(perr, 1'b1);
    chk(rdata, 32'h0);
  endtask
  initial begin
    {reset, psel, penable, pwrite, info_rate_opt_ok} = 5'h10;
    {dbi_enable, cal_pattern_dmi, temp_rate_code} = 5'h00;
    {paddr, cal_pattern, pwdata} = 48'h0;
    fails = 0;
    num_checks = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_refuse();
    t_rate();
    t_mask();
    t_cal();
    t_train();
    t_refout();
    t_linkrst();
    close_out();
  end
  // Watchdog against a hung handshake
  initial begin
    #1000000;
    fails++;
    close_out();
  end
endmodule
